//--- design/rxis_consts.svh
// constants for the receive interrupt/status block
// assumes inclusion by the package and the design module
`ifndef RXIS_CONSTS_SVH
`define RXIS_CONSTS_SVH
`define RXIS_ADDR_PRIMARY 7'h03
`define RXIS_ADDR_SECONDARY 7'h04
`define RXIS_ADDR_GPIO_DETAIL 7'h0E
`define RXIS_BIT_FFERR 7
`define RXIS_BIT_AFULL 4
`define RXIS_BIT_EXT 3
`define RXIS_BIT_PKVALID 1
`define RXIS_BIT_CRCERR 0
`define RXIS_PRIMARY_MASK 8'h9B
`define RXIS_RESET_FLAGS 8'h00
`endif

//--- design/rxis_pkg.sv
// types for the receive interrupt/status block
// assumes the constants header is on the include path
package rxis_pkg;
  `include "rxis_consts.svh"
  typedef struct packed {
    logic fifo_ovf;
    logic fifo_unf;
    logic fifo_rst;
    logic [6:0] fifo_count;
    logic [5:0] afull_thr;
    logic ext_event;
    logic pkt_ok;
    logic rx_abort;
    logic sync_ack;
    logic crc_bad;
    logic data_start;
  } rxis_evt_t;
  typedef struct packed {
    logic rd;
    logic [6:0] addr;
  } rxis_rd_t;
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] rdata;
    logic alert_n;
    logic afull_q;
  } rxis_state_t;
endpackage

//--- design/rxis_irq_status.sv
// primary interrupt/status register with active-low host alert line
// assumes events and reads come from logic on i_clk
`timescale 1ns/10ps
`default_nettype none
`include "rxis_consts.svh"
module rxis_irq_status
(
  input wire logic i_clk, // 125 MHz
  input wire logic i_rst, // sync, active high
  input wire rxis_pkg::rxis_evt_t i_evt, // receiver events
  input wire rxis_pkg::rxis_rd_t i_rd, // register read strobe
  input wire logic [7:0] i_enable, // interrupt enables
  input wire logic [7:0] i_secondary, // secondary flags
  input wire logic [7:0] i_gpio_detail, // per-pin detail
  output logic [7:0] o_rdata, // read data
  output logic o_host_alert_line_n // alert line
);
  import rxis_pkg::*;
  rxis_state_t st, next_st;
  logic afull_now;
  logic [7:0] set_v, clr_v, rise_v, rdclr_v;
  logic rd_primary;

  always_comb begin
    next_st = st;
    afull_now = i_evt.fifo_count > {1'b0, i_evt.afull_thr};
    rd_primary = i_rd.rd && (i_rd.addr == `RXIS_ADDR_PRIMARY);
    set_v = 8'h00;
    clr_v = 8'h00;
    set_v[`RXIS_BIT_FFERR] = i_evt.fifo_ovf | i_evt.fifo_unf;
    clr_v[`RXIS_BIT_FFERR] = i_evt.fifo_rst;
    set_v[`RXIS_BIT_EXT] = i_evt.ext_event;
    set_v[`RXIS_BIT_PKVALID] = i_evt.pkt_ok & ~i_evt.rx_abort;
    clr_v[`RXIS_BIT_PKVALID] = i_evt.sync_ack;
    set_v[`RXIS_BIT_CRCERR] = i_evt.crc_bad;
    clr_v[`RXIS_BIT_CRCERR] = i_evt.data_start;
    rdclr_v = rd_primary ? i_enable : 8'h00;
    rdclr_v[`RXIS_BIT_FFERR] = 1'b0;
    next_st.flags = (st.flags & ~clr_v & ~rdclr_v) | set_v;
    next_st.flags[`RXIS_BIT_AFULL] = afull_now;
    next_st.flags = next_st.flags & `RXIS_PRIMARY_MASK;
    next_st.afull_q = afull_now;
    // rise judged after read-clear, so a set during the read re-arms the line
    rise_v = next_st.flags & ~(st.flags & ~rdclr_v);
    rise_v[`RXIS_BIT_AFULL] = afull_now & ~st.afull_q;
    if (|(rise_v & i_enable & `RXIS_PRIMARY_MASK)) begin
      next_st.alert_n = 1'b0;
    end else if (rd_primary) begin
      next_st.alert_n = 1'b1;
    end
    next_st.rdata = st.rdata;
    if (i_rd.rd) begin
      case (i_rd.addr)
        `RXIS_ADDR_PRIMARY: next_st.rdata = st.flags;
        `RXIS_ADDR_SECONDARY: next_st.rdata = i_secondary;
        `RXIS_ADDR_GPIO_DETAIL: next_st.rdata = i_gpio_detail;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st.flags <= `RXIS_RESET_FLAGS;
      st.rdata <= 8'h00;
      st.alert_n <= 1'b1;
      st.afull_q <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_host_alert_line_n = st.alert_n;

  a_fferr_set: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_evt.fifo_ovf || i_evt.fifo_unf) |=> st.flags[7])
    else $error("fifo error flag not set");
  a_fferr_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.flags[7] && !i_evt.fifo_rst) |=> st.flags[7])
    else $error("fifo error flag cleared early");
  a_afull_level: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> (st.flags[4] == ($past(i_evt.fifo_count) > {1'b0, $past(i_evt.afull_thr)})))
    else $error("almost full flag wrong");
  a_pkv_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_evt.sync_ack && !i_evt.pkt_ok) |=> !st.flags[1])
    else $error("valid packet not cleared");
  a_crc_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_evt.data_start && !i_evt.crc_bad) |=> !st.flags[0])
    else $error("crc flag not cleared");
  a_alert_rise: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_evt.crc_bad && i_enable[0] && !st.flags[0]) |=> !o_host_alert_line_n)
    else $error("alert line not asserted");
  // read releases line absent new rise
  sequence s_quiet_read;
    rd_primary && !(|(rise_v & i_enable & `RXIS_PRIMARY_MASK));
  endsequence
  a_read_release: assert property (@(posedge i_clk) disable iff (i_rst)
    s_quiet_read |=> o_host_alert_line_n)
    else $error("alert line not released");
  a_status_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_primary && !i_enable[3] && st.flags[3]) |=> st.flags[3])
    else $error("status flag cleared by read");
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    (st.flags & 8'h64) == 8'h00)
    else $error("reserved bit set");

  a_fferr_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_evt.fifo_rst && !i_evt.fifo_ovf && !i_evt.fifo_unf) |=> !st.flags[7])
    else $error("fifo error flag not cleared by fifo reset");
  a_fferr_alert: assert property (@(posedge i_clk) disable iff (i_rst)
    ((i_evt.fifo_ovf || i_evt.fifo_unf) && i_enable[7] && !st.flags[7]) |=> !o_host_alert_line_n)
    else $error("alert line not asserted on fifo error");
  a_ext_set: assert property (@(posedge i_clk) disable iff (i_rst)
    i_evt.ext_event |=> st.flags[3])
    else $error("external event flag not set");
  a_ext_read_clear: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_primary && i_enable[3] && !i_evt.ext_event) |=> !st.flags[3])
    else $error("enabled flag not cleared by read");
  a_pkv_set: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_evt.pkt_ok && !i_evt.rx_abort) |=> st.flags[1])
    else $error("valid packet flag not set");
  a_pkv_abort: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_evt.rx_abort && (!st.flags[1] || i_evt.sync_ack)) |=> !st.flags[1])
    else $error("valid packet flag set by aborted packet");
  a_crc_set: assert property (@(posedge i_clk) disable iff (i_rst)
    i_evt.crc_bad |=> st.flags[0])
    else $error("crc flag not set");
  a_afull_alert: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_enable[4] && !st.flags[4] && (i_evt.fifo_count > {1'b0, i_evt.afull_thr}))
      |=> !o_host_alert_line_n)
    else $error("alert line not asserted on almost full");
  a_afull_read_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_primary && (i_evt.fifo_count > {1'b0, i_evt.afull_thr})) |=> st.flags[4])
    else $error("almost full flag cleared by read");
  a_alert_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!o_host_alert_line_n && !rd_primary) |=> !o_host_alert_line_n)
    else $error("alert line released without read");
  // line falls only with an enabled flag up
  a_alert_cause: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_host_alert_line_n) |-> |(st.flags & $past(i_enable) & `RXIS_PRIMARY_MASK))
    else $error("alert line asserted without enabled flag");
  a_reread_rise: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_primary && i_evt.crc_bad && i_enable[0]) |=> (!o_host_alert_line_n && st.flags[0]))
    else $error("event during read lost");
  // crc event then a quiet enabled read clears it
  sequence s_crc_event;
    i_evt.crc_bad && i_enable[0];
  endsequence
  sequence s_quiet_crc_read;
    rd_primary && i_enable[0] && !i_evt.crc_bad;
  endsequence
  a_crc_event_read: assert property (@(posedge i_clk) disable iff (i_rst)
    s_crc_event ##[1:8] s_quiet_crc_read |=> !st.flags[0])
    else $error("crc flag not cleared by read");
  a_read_primary: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_primary |=> (o_rdata == $past(st.flags)))
    else $error("primary read data wrong");
  a_read_secondary: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd.rd && (i_rd.addr == `RXIS_ADDR_SECONDARY)) |=> (o_rdata == $past(i_secondary)))
    else $error("secondary read data wrong");
  a_read_detail: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd.rd && (i_rd.addr == `RXIS_ADDR_GPIO_DETAIL)) |=> (o_rdata == $past(i_gpio_detail)))
    else $error("detail read data wrong");
  a_read_unmapped: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_rd.rd && (i_rd.addr != `RXIS_ADDR_PRIMARY) && (i_rd.addr != `RXIS_ADDR_SECONDARY)
      && (i_rd.addr != `RXIS_ADDR_GPIO_DETAIL))
      |=> (o_rdata == 8'h00))
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rd.rd |=> $stable(o_rdata))
    else $error("read data changed without read");
endmodule // rxis_irq_status
`default_nettype wire

//--- tb/rxis_host.sv
// host model issuing register reads
// assumes calls start at a falling edge
`timescale 1ns/10ps
`default_nettype none
module rxis_host (
  input wire logic i_clk, // clock
  input wire logic [7:0] i_rdata, // read data
  output var rxis_pkg::rxis_rd_t o_rd // read strobe
);
  import rxis_pkg::*;
  initial o_rd = '0;
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    o_rd = '{rd: 1'b1, addr: a};
    @(negedge i_clk);
    o_rd.rd = 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule // rxis_host
`default_nettype wire

//--- tb/rxis_irq_status_tb_top.sv
// bench for the receive interrupt/status block
// assumes the host model performs all reads
`timescale 1ns/10ps
`default_nettype none
module rxis_irq_status_tb_top;
  import rxis_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  rxis_evt_t ev = '0;
  rxis_rd_t rd;
  logic [7:0] en = 8'h9B;
  logic [7:0] rdata;
  logic alert_n;
  int err_total = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  rxis_irq_status dut (.i_clk(clk), .i_rst(rst), .i_evt(ev), .i_rd(rd), .i_enable(en),
    .i_secondary(8'hA5), .i_gpio_detail(8'h3C), .o_rdata(rdata),
    .o_host_alert_line_n(alert_n));
  rxis_host host (.i_clk(clk), .i_rdata(rdata), .o_rd(rd));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd_reg(a, d);
    chk(d, e);
  endtask
  // ends pulses, lets flags settle
  task automatic fire();
    @(negedge clk);
    ev = '{fifo_count: ev.fifo_count, afull_thr: ev.afull_thr, default: 1'b0};
    @(negedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_crc();
    ev.crc_bad = 1'b1;
    fire();
    chk({7'h00, alert_n}, 8'h00);
    rc(7'h03, 8'h01);
    chk({7'h00, alert_n}, 8'h01);
    rc(7'h03, 8'h00);
    $display("crc test done");
  endtask
  task automatic t_status();
    en = 8'h00;
    ev.pkt_ok = 1'b1;
    ev.crc_bad = 1'b1;
    fire();
    chk({7'h00, alert_n}, 8'h01);
    rc(7'h03, 8'h03);
    ev.data_start = 1'b1;
    fire();
    rc(7'h03, 8'h02);
    rc(7'h03, 8'h02);
    ev.sync_ack = 1'b1;
    fire();
    rc(7'h03, 8'h00);
    en = 8'h9B;
    $display("status test done");
  endtask
  task automatic t_fifo();
    ev.fifo_ovf = 1'b1;
    fire();
    rc(7'h03, 8'h80);
    ev.fifo_unf = 1'b1;
    fire();
    rc(7'h03, 8'h80);
    ev.fifo_rst = 1'b1;
    fire();
    rc(7'h03, 8'h00);
    ev.fifo_count = 7'd10;
    ev.afull_thr = 6'd5;
    fire();
    chk({7'h00, alert_n}, 8'h00);
    rc(7'h03, 8'h10);
    ev.fifo_count = 7'd3;
    fire();
    rc(7'h03, 8'h00);
    $display("fifo test done");
  endtask
  task automatic t_mixed();
    en = 8'h91;
    ev.pkt_ok = 1'b1;
    ev.crc_bad = 1'b1;
    ev.ext_event = 1'b1;
    fire();
    chk({7'h00, alert_n}, 8'h00);
    rc(7'h03, 8'h0B);
    rc(7'h03, 8'h0A);
    chk({7'h00, alert_n}, 8'h01);
    ev.crc_bad = 1'b1;
    fire();
    ev.crc_bad = 1'b1;
    rc(7'h03, 8'h0B);
    fire();
    chk({7'h00, alert_n}, 8'h00);
    rc(7'h03, 8'h0B);
    chk({7'h00, alert_n}, 8'h01);
    ev.sync_ack = 1'b1;
    ev.pkt_ok = 1'b1;
    ev.rx_abort = 1'b1;
    fire();
    rc(7'h03, 8'h08);
    en = 8'h9B;
    rc(7'h03, 8'h08);
    rc(7'h03, 8'h00);
    chk({7'h00, alert_n}, 8'h01);
    $display("mixed test done");
  endtask
  task automatic t_ext();
    ev.ext_event = 1'b1;
    fire();
    rc(7'h03, 8'h08);
    rc(7'h0E, 8'h3C);
    rc(7'h04, 8'hA5);
    rc(7'h10, 8'h00);
    rc(7'h03, 8'h00);
    $display("ext test done");
  endtask
  initial begin
    #40000;
    err_total++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk({7'h00, alert_n}, 8'h01);
    t_crc();
    t_status();
    t_mixed();
    t_fifo();
    t_ext();
    stop_test();
  end
endmodule // rxis_irq_status_tb_top
`default_nettype wire
